// >>> hdl/prwg_guard.sv
// Purpose: write guard in front of a peripheral's register file
// Assumes: bus inputs synchronous to MCLK_I, 40 MHz
// Notes:   blocked writes are dropped and flagged on BLOCKED_O; reads are never blocked
//
// Operation
// [RULE_01] a write to a register whose soft lock is set is dropped.
// [RULE_02] a soft lock is cleared by a software write or by reset.
// [RULE_03] while the hard lock is set every guarded write is dropped.
// [RULE_04] the hard lock, once set, is cleared only by reset.
// [RULE_05] unlocked registers may be limited to supervisor writes.
// [RULE_06] each guarded register owns one soft-lock set bit.
// [RULE_07] software sets the hard lock after configuring the block.
// [RULE_08] guard registers are decoded inside the peripheral window.
// [RULE_09] the master gives a privilege level with each access.
// [RULE_10] dropped writes change nothing and reads are unaffected.
// [RULE_11] with the hard lock set, lock and mode clears are ignored.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`include "prwg_map.svh"
module prwg_guard
   import prwg_pkg::*;
(
   input  wire logic        MCLK_I,
   input  wire logic        RST_N_I,
   input  wire logic [5:0]  ADDR_I,
   input  wire logic [31:0] WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   input  wire logic        SUPV_I,
   output logic      [31:0] RDATA_O,
   output logic             HARD_LOCK_O,
   output logic             BLOCKED_O
);
   // ------------------------------------------------------------------
   // request decode
   // ------------------------------------------------------------------
   prwg_req_t req;
   assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I,
                  supv: SUPV_I};

   logic [15:0] soft_lock_ff;
   logic        hard_lock_ff;
   logic        supv_only_ff;
   logic [1:0]  rsel_ff;
   logic [31:0] greg_ff;
   logic [31:0] mem_rdata;

   function automatic logic is_periph(input logic [5:0] a);
      return a <= `PRWG_PERIPH_LAST;
   endfunction : is_periph

   logic periph_wr;
   logic locked;
   logic priv_bad;
   logic wr_ok;
   logic gcr_wr;
   assign periph_wr = req.wr && is_periph(req.addr);
   // soft and hard lock first, privilege only when no lock applies
   assign locked   = soft_lock_ff[req.addr[3:0]] || hard_lock_ff; // [RULE_01] [RULE_03]
   assign priv_bad = !locked && supv_only_ff && !req.supv;        // [RULE_05] [RULE_09]
   assign wr_ok    = periph_wr && !locked && !priv_bad;           // [RULE_10]
   assign gcr_wr   = req.wr && req.addr == `PRWG_GCR_OFF;         // [RULE_08]

   // ------------------------------------------------------------------
   // lock state
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         soft_lock_ff <= `PRWG_SOFT_RST;                          // [RULE_02]
      end else if (req.wr && req.addr == `PRWG_SOFT_SET_OFF) begin
         soft_lock_ff <= soft_lock_ff | req.wdata[15:0];          // [RULE_06]
      end else if (req.wr && req.addr == `PRWG_SOFT_CLR_OFF
                   && !hard_lock_ff) begin
         soft_lock_ff <= soft_lock_ff & ~req.wdata[15:0];  // [RULE_02] [RULE_11]
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         hard_lock_ff <= 1'b0;
      end else if (gcr_wr && req.wdata[`PRWG_GCR_HARD_BIT]) begin
         hard_lock_ff <= 1'b1;                                    // [RULE_04]
      end
   end

   // supervisor-only may still be raised under hard lock, never dropped
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         supv_only_ff <= 1'b0;
      end else if (gcr_wr && (!hard_lock_ff
                   || req.wdata[`PRWG_GCR_SUPV_BIT])) begin
         supv_only_ff <= req.wdata[`PRWG_GCR_SUPV_BIT];           // [RULE_11]
      end
   end

   // ------------------------------------------------------------------
   // peripheral storage
   // ------------------------------------------------------------------
   prwg_regmem u_mem (
      .clk_i   (MCLK_I),
      .rst_n_i (RST_N_I),
      .we_i    (wr_ok),
      .waddr_i (req.addr[3:0]),
      .wdata_i (req.wdata),
      .raddr_i (req.addr[3:0]),
      .rdata_o (mem_rdata)
   );

   // ------------------------------------------------------------------
   // read path: unmapped addresses read zero
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         rsel_ff <= 2'h0;
         greg_ff <= 32'h0000_0000;
      end else begin
         rsel_ff <= 2'h0;
         greg_ff <= 32'h0000_0000;
         if (req.rd) begin
            if (is_periph(req.addr)) begin
               rsel_ff <= 2'h1;                                   // [RULE_10]
            end else if (req.addr == `PRWG_SOFT_SET_OFF ||
                         req.addr == `PRWG_SOFT_CLR_OFF) begin
               rsel_ff <= 2'h2;
               greg_ff <= {16'h0000, soft_lock_ff};
            end else if (req.addr == `PRWG_GCR_OFF) begin
               rsel_ff <= 2'h2;
               greg_ff <= {30'h0, supv_only_ff, hard_lock_ff};
            end
         end
      end
   end

   always_comb begin
      unique case (rsel_ff)
         2'h1:    RDATA_O = mem_rdata;
         2'h2:    RDATA_O = greg_ff;
         default: RDATA_O = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
         HARD_LOCK_O <= 1'b0;
         BLOCKED_O   <= 1'b0;
      end else begin
         HARD_LOCK_O <= hard_lock_ff;
         BLOCKED_O   <= periph_wr && !wr_ok;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_locked_write;
      req.wr && is_periph(req.addr) && soft_lock_ff[req.addr[3:0]];
   endsequence

   soft_lock_block_a : assert property (s_locked_write |-> !wr_ok) // [RULE_01]
      else $error("write passed a soft lock");
   hard_lock_block_a : assert property (hard_lock_ff |-> !wr_ok) // [RULE_03]
      else $error("write passed the hard lock");
   hard_lock_hold_a : assert property (hard_lock_ff |=> hard_lock_ff) // [RULE_04]
      else $error("hard lock dropped without reset");
   supv_only_a : assert property // [RULE_05]
      (supv_only_ff && !req.supv |-> !wr_ok)
      else $error("user write passed supervisor-only mode");
   soft_clr_a : assert property // [RULE_02]
      (req.wr && req.addr == `PRWG_SOFT_CLR_OFF && !hard_lock_ff
       && !(req.addr == `PRWG_SOFT_SET_OFF)
       |=> (soft_lock_ff & $past(req.wdata[15:0])) == 16'h0000)
      else $error("soft lock clear did not take");
   soft_set_a : assert property // [RULE_06]
      (req.wr && req.addr == `PRWG_SOFT_SET_OFF
       |=> (soft_lock_ff & $past(req.wdata[15:0])) == $past(req.wdata[15:0]))
      else $error("soft lock set did not take");
   hard_keep_soft_a : assert property // [RULE_11]
      (hard_lock_ff |=> (soft_lock_ff & $past(soft_lock_ff))
                         == $past(soft_lock_ff))
      else $error("soft lock cleared under hard lock");
   blocked_flag_a : assert property // [RULE_10]
      (periph_wr && locked |=> BLOCKED_O)
      else $error("blocked write not flagged");
endmodule : prwg_guard

// >>> hdl/prwg_map.svh
// Purpose: offsets, field positions and reset values of the write guard
// Assumes: word-indexed register port, 32-bit data
// Notes:   guard registers sit in the top part of the protected window
`ifndef PRWG_MAP_SVH
`define PRWG_MAP_SVH

// ------------------------------------------------------------------
// address map (word index, 6-bit window)
// ------------------------------------------------------------------
`define PRWG_NREGS         16
`define PRWG_PERIPH_LAST   6'h0f
`define PRWG_SOFT_SET_OFF  6'h20
`define PRWG_SOFT_CLR_OFF  6'h21
`define PRWG_GCR_OFF       6'h22

// ------------------------------------------------------------------
// guard_global_control fields
// ------------------------------------------------------------------
`define PRWG_GCR_HARD_BIT  0
`define PRWG_GCR_SUPV_BIT  1

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define PRWG_PERIPH_RST    32'h0000_0000
`define PRWG_SOFT_RST      16'h0000
`endif

// >>> hdl/prwg_pkg.sv
// Purpose: types shared by the write guard files
// Assumes: nothing
// Notes:   none
package prwg_pkg;
   typedef struct packed {
      logic [5:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
      logic        supv;
   } prwg_req_t;
endpackage : prwg_pkg

// >>> hdl/prwg_regmem.sv
// Purpose: storage of the guarded peripheral registers
// Assumes: one write or one read per cycle
// Notes:   read data registered, one cycle after the read strobe
`timescale 1ns/100ps
`include "prwg_map.svh"
module prwg_regmem
   import prwg_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  waddr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  raddr_i,
   output logic      [31:0] rdata_o
);
   logic [31:0] mem_ff [`PRWG_NREGS];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < `PRWG_NREGS; i++) begin
            mem_ff[i] <= `PRWG_PERIPH_RST;
         end
      end else if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 32'h0000_0000;
      end else begin
         rdata_o <= mem_ff[raddr_i];
      end
   end
endmodule : prwg_regmem

// >>> verif/prwg_master.sv
// Purpose: bus master model for the guard's register port
// Assumes: one strobe a cycle, changed just after the rising edge
// Notes:   idle lines flip so stale values never look valid
`timescale 1ns/100ps
module prwg_master
   import prwg_pkg::*;
(
   input  wire logic clk_i,
   output prwg_req_t req_o
);
   // ------------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------------
   initial req_o = '0;
   task automatic wr(input logic [5:0] a, input logic [31:0] d,
                     input logic s);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, supv: s};
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic s);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: ~req_o.wdata, wr: 1'b0, rd: 1'b1, supv: s};
   endtask : rd
   task automatic idle();
      @(posedge clk_i);
      req_o <= '{addr: ~req_o.addr, wdata: ~req_o.wdata, wr: 1'b0,
                 rd: 1'b0, supv: ~req_o.supv};
   endtask : idle
endmodule : prwg_master

// >>> verif/tb.sv
// Purpose: self-checking bench of the write guard
// Assumes: model of locks and registers kept beside the stimulus
// Notes:   expectations queue up in issue order
`timescale 1ns/100ps
`include "prwg_map.svh"
module tb
   import prwg_pkg::*;
;
   // ------------------------------------------------------------------
   // signals and model
   // ------------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        pend = 1'b0;
   prwg_req_t   req;
   logic [31:0] rdata;
   logic        hard_o;
   logic        blk_o;
   logic [32:0] exp_q[$];
   logic [31:0] regs_m[16];
   logic [15:0] soft_m;
   logic        hard_m;
   logic        supv_m;
   int          fail_count = 0;
   int          checked = 0;
   int          seed_v;
   always #12.5 mclk = ~mclk;
   prwg_master u_prwg_master (.clk_i(mclk), .req_o(req));
   prwg_guard u_prwg_guard (.MCLK_I(mclk), .RST_N_I(rst_n),
      .ADDR_I(req.addr), .WDATA_I(req.wdata), .WR_I(req.wr),
      .RD_I(req.rd), .SUPV_I(req.supv), .RDATA_O(rdata),
      .HARD_LOCK_O(hard_o), .BLOCKED_O(blk_o));
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      if (fail_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   task automatic do_reset();
      rst_n <= 1'b0;
      soft_m = `PRWG_SOFT_RST;
      hard_m = 1'b0;
      supv_m = 1'b0;
      foreach (regs_m[i]) regs_m[i] = `PRWG_PERIPH_RST;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
   endtask : do_reset
   task automatic bw(input logic [5:0] a, input logic [31:0] d,
                     input logic s);
      logic g;
      logic b;
      g = a <= `PRWG_PERIPH_LAST;
      b = g && (soft_m[a[3:0]] | hard_m | (supv_m & ~s));
      if (g && !b) regs_m[a[3:0]] = d;
      if (a == `PRWG_SOFT_SET_OFF) soft_m = soft_m | d[15:0];
      if (a == `PRWG_SOFT_CLR_OFF && !hard_m) soft_m = soft_m & ~d[15:0];
      if (a == `PRWG_GCR_OFF) begin
         supv_m = d[`PRWG_GCR_SUPV_BIT] | (supv_m & hard_m);
         hard_m = hard_m | d[`PRWG_GCR_HARD_BIT];
      end
      exp_q.push_back({b, 32'h0});
      u_prwg_master.wr(a, d, s);
   endtask : bw
   task automatic br(input logic [5:0] a);
      logic [31:0] v;
      v = '0;
      if (a <= `PRWG_PERIPH_LAST) v = regs_m[a[3:0]];
      if (a == `PRWG_SOFT_SET_OFF || a == `PRWG_SOFT_CLR_OFF) v = soft_m;
      if (a == `PRWG_GCR_OFF) v = {30'h0, supv_m, hard_m};
      exp_q.push_back({1'b0, v});
      u_prwg_master.rd(a, 1'($urandom));
   endtask : br
   // every peripheral register written back to back, then all read back with the three guard registers and one unmapped address
   task automatic sweep();
      for (int i = 0; i < `PRWG_NREGS; i++) bw(6'(i), $urandom, 1'($urandom));
      for (int i = 0; i < `PRWG_NREGS; i++) br(6'(i));
      br(`PRWG_SOFT_SET_OFF);
      br(`PRWG_SOFT_CLR_OFF);
      br(`PRWG_GCR_OFF);
      br(6'h30);
      u_prwg_master.idle();
   endtask : sweep
   // ------------------------------------------------------------------
   // watcher and main sequence
   // ------------------------------------------------------------------
   always @(posedge mclk) pend <= (req.wr | req.rd) & rst_n;
   always @(negedge mclk) begin
      logic [32:0] e;
      if (pend === 1'b1) begin
         e = (exp_q.size() == 0) ? '1 : exp_q.pop_front();
         chk("rdata", e[31:0], rdata);
         chk("blocked", {31'h0, e[32]}, {31'h0, blk_o});
      end
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      end_of_test();
   end
   initial begin
      seed_v = $urandom(32'h8733);
      do_reset();
      sweep();
      bw(6'h30, $urandom, 1'b1);
      bw(`PRWG_SOFT_SET_OFF, $urandom, 1'b0);
      sweep();
      bw(`PRWG_SOFT_CLR_OFF, $urandom, 1'b0);
      sweep();
      bw(`PRWG_GCR_OFF, 32'h2, 1'b1);
      sweep();
      bw(`PRWG_GCR_OFF, 32'h3, 1'b1);
      bw(`PRWG_SOFT_CLR_OFF, 32'hffff, 1'b1);
      bw(`PRWG_GCR_OFF, 32'h0, 1'b1);
      sweep();
      chk("hard_lock", 32'h1, {31'h0, hard_o});
      do_reset();
      repeat (2) @(posedge mclk);
      chk("hard_lock", 32'h0, {31'h0, hard_o});
      sweep();
      end_of_test();
   end
endmodule : tb
